//--- include/clk_ctrl_pkg.sv
// Constants, register map and state types of the clock and power-down controller.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package clk_ctrl_pkg;

  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFS_PWR_CTRL = 8'h00;
  localparam logic [7:0] OFS_HS_GATE = 8'h04;
  localparam logic [7:0] OFS_PERIPH_GATE = 8'h08;
  localparam logic [7:0] OFS_STABLE = 8'h0C;
  localparam logic [7:0] OFS_CORE_SEL = 8'h10;
  localparam logic [7:0] OFS_PSEL_A = 8'h14;
  localparam logic [7:0] OFS_DIV_NUM = 8'h18;
  localparam logic [7:0] OFS_PSEL_B = 8'h1C;
  localparam logic [7:0] OFS_PLL_CTRL = 8'h20;
  localparam logic [7:0] OFS_FREQ_DIV = 8'h24;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int BIT_HF_XTAL = 0;
  localparam int BIT_LF_XTAL = 1;
  localparam int BIT_FAST_RC = 2;
  localparam int BIT_SLOW_RC = 3;
  localparam int BIT_WAKE_DLY = 4;
  localparam int BIT_WAKE_IRQ_EN = 5;
  localparam int BIT_WAKE_FLAG = 6;
  localparam int BIT_PD_REQ = 7;
  localparam int BIT_WAIT_CPU = 8;
  localparam int BIT_DMA_GATE = 1;
  localparam int BIT_FLASH_GATE = 2;
  localparam int BIT_EXT_BUS_GATE = 3;
  localparam int BIT_DIV_GATE = 6;
  localparam int BIT_DIV_RUN = 4;
  localparam int BIT_SW_FAIL = 7;

  // --------------------------------------------------------------------------
  // Reset values and source codes
  // --------------------------------------------------------------------------
  localparam logic [31:0] RST_HS_GATE = 32'h0000000D;
  localparam logic [31:0] RST_PERIPH_GATE = 32'h00000000;
  localparam logic [31:0] RST_PSEL_A = 32'hFFFFFFFF;
  localparam logic [31:0] RST_PSEL_B = 32'h000000F0;
  localparam logic [31:0] RST_DIV_NUM = 32'h00000000;
  localparam logic [31:0] RST_PLL_CTRL = 32'h0005C22E;
  localparam logic [4:0] RST_FREQ_DIV = 5'h00;
  localparam logic [2:0] RST_TICK_SRC = 3'h7;
  localparam logic [2:0] SRC_HF_XTAL = 3'h0;
  localparam logic [2:0] SRC_LF_XTAL = 3'h1;
  localparam logic [2:0] SRC_PLL = 3'h2;
  localparam logic [2:0] SRC_SLOW_RC = 3'h3;
  localparam int DIV_STAGES = 16;

  typedef enum logic [1:0] {
    PM_RUN,
    PM_IDLE,
    PM_DOWN,
    PM_WAKE_DLY
  } power_state_t;

endpackage : clk_ctrl_pkg

//--- verilog/clock_power_down_controller.sv
// Clock and power-down controller with a classic Wishbone register slave.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module clock_power_down_controller #(
  parameter int WAKE_DLY_HF_CYCLES = 4096,
  parameter int WAKE_DLY_RC_CYCLES = 256
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic regs_unlocked,
  input wire logic [2:0] cfg_default_source,
  input wire logic wait_for_interrupt_instr,
  input wire logic tick_use_external,
  input wire logic [7:0] wake_src,
  input wire logic [4:0] osc_stable,
  input wire logic [31:0] periph_slow_source,
  output logic hf_crystal_on,
  output logic low_freq_crystal_on,
  output logic fast_rc_osc_on,
  output logic slow_rc_osc_on,
  output logic pll_on,
  output logic sys_clock_en,
  output logic cpu_clock_en,
  output logic [4:0] sys_source_onehot,
  output logic [4:0] tick_source_onehot,
  output logic ext_bus_clock_gate,
  output logic flash_prog_clock_gate,
  output logic dma_clock_gate,
  output logic [31:0] periph_clock_en,
  output logic wake_irq,
  output logic in_power_down,
  output logic divided_clock_out
);

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  logic [8:0] pwr_q;
  logic [3:1] hs_gate_q;
  logic [31:0] periph_gate_q;
  logic sw_fail_q;
  logic [2:0] core_src_q;
  logic [2:0] tick_src_q;
  logic [31:0] psel_a_q;
  logic [31:0] div_num_q;
  logic [31:0] psel_b_q;
  logic [31:0] pll_ctrl_q;
  logic [4:0] freq_div_q;
  logic [31:0] rd_d;
  logic [31:0] wmask;
  logic wr_en;
  logic wr_prot;
  logic [4:0] stable_q1;
  logic [4:0] stable_q2;
  logic [7:0] wake_q1;
  logic [7:0] wake_q2;
  logic wake_any;
  clk_ctrl_pkg::power_state_t state_q;
  clk_ctrl_pkg::power_state_t state_d;
  logic [12:0] dly_cnt_q;
  logic wake_now;
  logic down_d;
  localparam int DIV_STAGES_W = clk_ctrl_pkg::DIV_STAGES;
  logic [DIV_STAGES_W-1:0] div_cnt_q;
  logic [DIV_STAGES_W-1:0] div_cnt_d;

  // --------------------------------------------------------------------------
  // Synchronisers for pins from other domains
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wake_q1 <= 8'h00;
      wake_q2 <= 8'h00;
      stable_q1 <= 5'h00;
      stable_q2 <= 5'h00;
    end else begin
      wake_q1 <= wake_src;
      wake_q2 <= wake_q1;
      stable_q1 <= osc_stable;
      stable_q2 <= stable_q1;
    end
  end

  assign wake_any = |wake_q2;

  // --------------------------------------------------------------------------
  // Wishbone slave: one wait state, the write lands on the ack edge
  // --------------------------------------------------------------------------
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wr_prot = wr_en && regs_unlocked;

  always_comb begin
    rd_d = 32'h00000000;
    unique case (wb_adr_i)
      clk_ctrl_pkg::OFS_PWR_CTRL: rd_d = {23'h000000, pwr_q};
      clk_ctrl_pkg::OFS_HS_GATE: rd_d = {28'h0000000, hs_gate_q, 1'b1};
      clk_ctrl_pkg::OFS_PERIPH_GATE: rd_d = periph_gate_q;
      clk_ctrl_pkg::OFS_STABLE: rd_d = {24'h000000, sw_fail_q, 2'b00, stable_q2};
      clk_ctrl_pkg::OFS_CORE_SEL: rd_d = {26'h0000000, tick_src_q, core_src_q};
      clk_ctrl_pkg::OFS_PSEL_A: rd_d = psel_a_q;
      clk_ctrl_pkg::OFS_DIV_NUM: rd_d = div_num_q;
      clk_ctrl_pkg::OFS_PSEL_B: rd_d = psel_b_q;
      clk_ctrl_pkg::OFS_PLL_CTRL: rd_d = pll_ctrl_q;
      clk_ctrl_pkg::OFS_FREQ_DIV: rd_d = {27'h0000000, freq_div_q};
      default: rd_d = 32'h00000000;
    endcase
  end

  // Unmapped addresses are acked with zero data so a stray access never hangs the bus.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= rd_d;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Power-down control register
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pwr_q <= 9'h000;
      pwr_q[clk_ctrl_pkg::BIT_WAKE_DLY] <= 1'b1;
      pwr_q[clk_ctrl_pkg::BIT_FAST_RC] <= 1'b1;
      pwr_q[clk_ctrl_pkg::BIT_HF_XTAL] <= (cfg_default_source == clk_ctrl_pkg::SRC_HF_XTAL);
    end else begin
      if (wr_prot && wb_adr_i == clk_ctrl_pkg::OFS_PWR_CTRL) begin
        if (wb_sel_i[0]) begin
          pwr_q[5:0] <= wb_dat_i[5:0];
          pwr_q[clk_ctrl_pkg::BIT_PD_REQ] <= wb_dat_i[clk_ctrl_pkg::BIT_PD_REQ];
        end
        if (wb_sel_i[1]) begin
          pwr_q[clk_ctrl_pkg::BIT_WAIT_CPU] <= wb_dat_i[clk_ctrl_pkg::BIT_WAIT_CPU];
        end
      end
      // The wake flag is not protected; a wake event in the clearing cycle wins.
      if (wake_now) begin
        pwr_q[clk_ctrl_pkg::BIT_WAKE_FLAG] <= 1'b1;
        pwr_q[clk_ctrl_pkg::BIT_PD_REQ] <= 1'b0;
      end else if (wr_en && wb_adr_i == clk_ctrl_pkg::OFS_PWR_CTRL && wb_sel_i[0]
                   && wb_dat_i[clk_ctrl_pkg::BIT_WAKE_FLAG]) begin
        pwr_q[clk_ctrl_pkg::BIT_WAKE_FLAG] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Plain control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hs_gate_q <= clk_ctrl_pkg::RST_HS_GATE[3:1];
      periph_gate_q <= clk_ctrl_pkg::RST_PERIPH_GATE;
      psel_a_q <= clk_ctrl_pkg::RST_PSEL_A;
      psel_b_q <= clk_ctrl_pkg::RST_PSEL_B;
      div_num_q <= clk_ctrl_pkg::RST_DIV_NUM;
      pll_ctrl_q <= clk_ctrl_pkg::RST_PLL_CTRL;
      freq_div_q <= clk_ctrl_pkg::RST_FREQ_DIV;
    end else if (wr_en) begin
      unique case (wb_adr_i)
        clk_ctrl_pkg::OFS_HS_GATE: begin
          if (wb_sel_i[0]) begin
            hs_gate_q <= wb_dat_i[3:1];
          end
        end
        clk_ctrl_pkg::OFS_PERIPH_GATE: begin
          periph_gate_q <= (periph_gate_q & ~wmask) | (wb_dat_i & wmask);
        end
        clk_ctrl_pkg::OFS_PSEL_A: psel_a_q <= (psel_a_q & ~wmask) | (wb_dat_i & wmask);
        clk_ctrl_pkg::OFS_PSEL_B: psel_b_q <= (psel_b_q & ~wmask) | (wb_dat_i & wmask);
        clk_ctrl_pkg::OFS_DIV_NUM: div_num_q <= (div_num_q & ~wmask) | (wb_dat_i & wmask);
        clk_ctrl_pkg::OFS_PLL_CTRL: pll_ctrl_q <= (pll_ctrl_q & ~wmask) | (wb_dat_i & wmask);
        clk_ctrl_pkg::OFS_FREQ_DIV: begin
          if (wb_sel_i[0]) begin
            freq_div_q <= wb_dat_i[4:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Source selection and switch-fail flag
  // --------------------------------------------------------------------------
  function automatic logic [4:0] core_onehot(input logic [2:0] code);
    logic [4:0] oh;
    oh = 5'h00;
    if (code[2]) begin
      oh[4] = 1'b1;
    end else begin
      oh[code[1:0]] = 1'b1;
    end
    return oh;
  endfunction : core_onehot

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      core_src_q <= cfg_default_source[2] ? 3'h7 : 3'h0;
      tick_src_q <= clk_ctrl_pkg::RST_TICK_SRC;
      sw_fail_q <= 1'b0;
    end else begin
      if (wr_prot && wb_adr_i == clk_ctrl_pkg::OFS_CORE_SEL && wb_sel_i[0]) begin
        core_src_q <= wb_dat_i[2:0];
        tick_src_q <= wb_dat_i[5:3];
        sw_fail_q <= ~|(core_onehot(wb_dat_i[2:0]) & stable_q2);
      end else if (wr_prot && wb_adr_i == clk_ctrl_pkg::OFS_STABLE && wb_sel_i[0]
                   && wb_dat_i[clk_ctrl_pkg::BIT_SW_FAIL]) begin
        sw_fail_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Power mode sequencer
  // --------------------------------------------------------------------------
  assign wake_now = (state_q == clk_ctrl_pkg::PM_DOWN) && wake_any;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      clk_ctrl_pkg::PM_RUN, clk_ctrl_pkg::PM_IDLE: begin
        if (pwr_q[clk_ctrl_pkg::BIT_PD_REQ] && !pwr_q[clk_ctrl_pkg::BIT_WAIT_CPU]) begin
          state_d = clk_ctrl_pkg::PM_DOWN;
        end else if (pwr_q[clk_ctrl_pkg::BIT_PD_REQ] && wait_for_interrupt_instr) begin
          state_d = clk_ctrl_pkg::PM_DOWN;
        end else if (!pwr_q[clk_ctrl_pkg::BIT_PD_REQ] && wait_for_interrupt_instr) begin
          state_d = clk_ctrl_pkg::PM_IDLE;
        end else begin
          state_d = clk_ctrl_pkg::PM_RUN;
        end
      end
      clk_ctrl_pkg::PM_DOWN: begin
        if (wake_any) begin
          if (pwr_q[clk_ctrl_pkg::BIT_WAKE_DLY] && (core_src_q[2]
              || core_src_q == clk_ctrl_pkg::SRC_HF_XTAL)) begin
            state_d = clk_ctrl_pkg::PM_WAKE_DLY;
          end else begin
            state_d = clk_ctrl_pkg::PM_RUN;
          end
        end
      end
      clk_ctrl_pkg::PM_WAKE_DLY: begin
        if (dly_cnt_q == 13'h0000) begin
          state_d = clk_ctrl_pkg::PM_RUN;
        end
      end
    endcase
  end

  // The delay counts mclk edges while sys_clock_en is still held low; its length follows the selected source.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= clk_ctrl_pkg::PM_RUN;
      dly_cnt_q <= 13'h0000;
    end else begin
      state_q <= state_d;
      if (wake_now) begin
        dly_cnt_q <= core_src_q[2] ? 13'(WAKE_DLY_RC_CYCLES - 1)
                                   : 13'(WAKE_DLY_HF_CYCLES - 1);
      end else if (state_q == clk_ctrl_pkg::PM_WAKE_DLY) begin
        dly_cnt_q <= dly_cnt_q - 13'h0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Clock enables
  // --------------------------------------------------------------------------
  assign down_d = state_d == clk_ctrl_pkg::PM_DOWN;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hf_crystal_on <= 1'b0;
      low_freq_crystal_on <= 1'b0;
      fast_rc_osc_on <= 1'b0;
      slow_rc_osc_on <= 1'b0;
      pll_on <= 1'b0;
      sys_clock_en <= 1'b0;
      cpu_clock_en <= 1'b0;
      in_power_down <= 1'b0;
    end else begin
      hf_crystal_on <= pwr_q[clk_ctrl_pkg::BIT_HF_XTAL] && !down_d;
      fast_rc_osc_on <= pwr_q[clk_ctrl_pkg::BIT_FAST_RC] && !down_d;
      low_freq_crystal_on <= pwr_q[clk_ctrl_pkg::BIT_LF_XTAL];
      slow_rc_osc_on <= pwr_q[clk_ctrl_pkg::BIT_SLOW_RC];
      pll_on <= !down_d;
      sys_clock_en <= !down_d && state_d != clk_ctrl_pkg::PM_WAKE_DLY;
      cpu_clock_en <= state_d == clk_ctrl_pkg::PM_RUN;
      in_power_down <= down_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wake_irq <= 1'b0;
      ext_bus_clock_gate <= 1'b0;
      flash_prog_clock_gate <= 1'b0;
      dma_clock_gate <= 1'b0;
      periph_clock_en <= 32'h00000000;
      sys_source_onehot <= 5'h00;
      tick_source_onehot <= 5'h00;
    end else begin
      wake_irq <= pwr_q[clk_ctrl_pkg::BIT_WAKE_FLAG] && pwr_q[clk_ctrl_pkg::BIT_WAKE_IRQ_EN];
      ext_bus_clock_gate <= hs_gate_q[clk_ctrl_pkg::BIT_EXT_BUS_GATE] && sys_clock_en;
      flash_prog_clock_gate <= hs_gate_q[clk_ctrl_pkg::BIT_FLASH_GATE] && sys_clock_en;
      dma_clock_gate <= hs_gate_q[clk_ctrl_pkg::BIT_DMA_GATE] && sys_clock_en;
      periph_clock_en <= periph_gate_q & (in_power_down ? periph_slow_source : 32'hFFFFFFFF);
      sys_source_onehot <= core_onehot(core_src_q);
      tick_source_onehot <= tick_use_external ? core_onehot(tick_src_q) : 5'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Frequency divider
  // --------------------------------------------------------------------------
  // Clearing the run bit lets the chain run on until the tap is low, so no runt pulse.
  always_comb begin
    div_cnt_d = div_cnt_q;
    if (periph_gate_q[clk_ctrl_pkg::BIT_DIV_GATE]
        && (freq_div_q[clk_ctrl_pkg::BIT_DIV_RUN] || div_cnt_q[freq_div_q[3:0]])) begin
      div_cnt_d = div_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      div_cnt_q <= 16'h0000;
      divided_clock_out <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      divided_clock_out <= div_cnt_d[freq_div_q[3:0]];
    end
  end

endmodule : clock_power_down_controller

//--- verif/clk_ctrl_props.sv
// Port assertions of the clock and power-down controller.
`timescale 1ns/1ps
module clk_ctrl_props (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tick_use_external,
  input wire logic [7:0] wake_src,
  input wire logic [31:0] periph_slow_source,
  input wire logic hf_crystal_on,
  input wire logic fast_rc_osc_on,
  input wire logic pll_on,
  input wire logic sys_clock_en,
  input wire logic [4:0] sys_source_onehot,
  input wire logic [4:0] tick_source_onehot,
  input wire logic ext_bus_clock_gate,
  input wire logic flash_prog_clock_gate,
  input wire logic dma_clock_gate,
  input wire logic [31:0] periph_clock_en,
  input wire logic wake_irq,
  input wire logic in_power_down
);
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_pd_clk; in_power_down |-> !sys_clock_en && !pll_on; endproperty
  a_pd_clk: assert property (p_pd_clk) else $error("clock running in power-down");
  property p_pd_osc; in_power_down |-> !hf_crystal_on && !fast_rc_osc_on; endproperty
  a_pd_osc: assert property (p_pd_osc) else $error("fast source on in power-down");
  // The gated vector lags the state by one edge, so only settled cycles are judged.
  property p_pd_periph;
    in_power_down && $past(in_power_down) |-> (periph_clock_en & ~periph_slow_source) == 32'h0;
  endproperty
  a_pd_periph: assert property (p_pd_periph) else $error("fast peripheral clock on");
  property p_gates;
    ext_bus_clock_gate || flash_prog_clock_gate || dma_clock_gate |-> $past(sys_clock_en);
  endproperty
  a_gates: assert property (p_gates) else $error("bus gate on without system clock");
  property p_sys_src; sys_clock_en |-> $onehot(sys_source_onehot); endproperty
  a_sys_src: assert property (p_sys_src) else $error("system source not one-hot");
  property p_tick_off; !tick_use_external |=> tick_source_onehot == 5'h00; endproperty
  a_tick_off: assert property (p_tick_off) else $error("tick source while internal");
  property p_pd_hold; (in_power_down && wake_src == 8'h00) [*6] |=> in_power_down; endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("left power-down without wake");
  c_enter: cover property ($rose(in_power_down));
  c_delay: cover property ($fell(in_power_down) ##1 !sys_clock_en);
  c_irq: cover property ($rose(wake_irq));
endmodule : clk_ctrl_props

bind clock_power_down_controller clk_ctrl_props u_props (.mclk, .rst_b, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .tick_use_external, .wake_src, .periph_slow_source, .hf_crystal_on, .fast_rc_osc_on,
  .pll_on, .sys_clock_en, .sys_source_onehot, .tick_source_onehot, .ext_bus_clock_gate,
  .flash_prog_clock_gate, .dma_clock_gate, .periph_clock_en, .wake_irq, .in_power_down);

//--- verif/core_sleep_model.sv
// Model of the sleeping core and of the wake event sources.
`timescale 1ns/1ps
module core_sleep_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sleep_cmd,
  input wire logic wake_cmd,
  input wire logic [2:0] wake_sel,
  output logic wait_for_interrupt_instr,
  output logic [7:0] wake_src
);
  // The core stays asleep until an interrupt arrives, as a real core would.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wait_for_interrupt_instr <= 1'b0;
      wake_src <= 8'h00;
    end else if (wake_cmd) begin
      wake_src <= 8'h01 << wake_sel;
      wait_for_interrupt_instr <= 1'b0;
    end else begin
      wake_src <= 8'h00;
      if (sleep_cmd) begin
        wait_for_interrupt_instr <= 1'b1;
      end
    end
  end
endmodule : core_sleep_model

//--- verif/clock_power_down_controller_bench.sv
// Self-checking testbench of the clock and power-down controller.
`timescale 1ns/1ps
module clock_power_down_controller_bench;
  localparam int HF_DLY = 16;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, periph_clock_en, rd;
  logic wb_ack_o, hf_crystal_on, low_freq_crystal_on, fast_rc_osc_on, slow_rc_osc_on, pll_on;
  logic sys_clock_en, cpu_clock_en, ext_bus_clock_gate, flash_prog_clock_gate, dma_clock_gate;
  logic wake_irq, in_power_down, divided_clock_out, wait_for_interrupt_instr;
  logic [4:0] sys_source_onehot, tick_source_onehot;
  logic [7:0] wake_src;
  logic regs_unlocked = 1'b0, tick_use_external = 1'b0, sleep_cmd = 1'b0, wake_cmd = 1'b0;
  logic [2:0] wake_sel = 3'h0, cfg = 3'h0;
  int n_fail = 0, samples_checked = 0;
  always #25 mclk = ~mclk;
  clock_power_down_controller #(.WAKE_DLY_HF_CYCLES(HF_DLY), .WAKE_DLY_RC_CYCLES(4)) u_dut (
    .mclk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .regs_unlocked, .cfg_default_source(cfg), .wait_for_interrupt_instr,
    .tick_use_external, .wake_src, .osc_stable(5'h1F), .periph_slow_source(32'h0000000F),
    .hf_crystal_on, .low_freq_crystal_on, .fast_rc_osc_on, .slow_rc_osc_on, .pll_on,
    .sys_clock_en, .cpu_clock_en, .sys_source_onehot, .tick_source_onehot, .ext_bus_clock_gate,
    .flash_prog_clock_gate, .dma_clock_gate, .periph_clock_en, .wake_irq, .in_power_down,
    .divided_clock_out);
  core_sleep_model u_core (.mclk, .rst_b, .sleep_cmd, .wake_cmd, .wake_sel,
    .wait_for_interrupt_instr, .wake_src);
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task final_report;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // Outputs are registered, so every access leaves two edges for them to settle.
  task bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      final_report();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    tick(2);
  endtask : bus
  task wr(input logic [7:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat);
  endtask : wr
  task rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    bus(1'b0, adr, 32'h0);
    chk(rd, exp, what);
  endtask : rdchk
  task wait_pd(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge mclk);
      if (in_power_down === lvl) break;
    end
    chk(in_power_down, lvl, "power-down state");
  endtask : wait_pd
  task count_rises(input int cyc, output int r);
    logic prev;
    prev = divided_clock_out;
    r = 0;
    repeat (cyc) begin
      @(posedge mclk);
      if (divided_clock_out === 1'b1 && prev === 1'b0) r++;
      prev = divided_clock_out;
    end
  endtask : count_rises
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task t_reset;
    rdchk(clk_ctrl_pkg::OFS_PWR_CTRL, 32'h15, "power control reset");
    rdchk(clk_ctrl_pkg::OFS_HS_GATE, clk_ctrl_pkg::RST_HS_GATE, "bus gate reset");
    rdchk(clk_ctrl_pkg::OFS_CORE_SEL, 32'h38, "core select reset");
    rdchk(clk_ctrl_pkg::OFS_PSEL_A, clk_ctrl_pkg::RST_PSEL_A, "select a reset");
    rdchk(clk_ctrl_pkg::OFS_PSEL_B, clk_ctrl_pkg::RST_PSEL_B, "select b reset");
    rdchk(clk_ctrl_pkg::OFS_PLL_CTRL, clk_ctrl_pkg::RST_PLL_CTRL, "pll reset");
    rdchk(clk_ctrl_pkg::OFS_FREQ_DIV, 32'h0, "divider reset");
    rdchk(8'h40, 32'h0, "unmapped read");
    chk({hf_crystal_on, fast_rc_osc_on, slow_rc_osc_on}, 3'h6, "oscillators at reset");
  endtask : t_reset
  task t_protect;
    wr(clk_ctrl_pkg::OFS_PWR_CTRL, 32'h1F);
    rdchk(clk_ctrl_pkg::OFS_PWR_CTRL, 32'h15, "locked write");
    regs_unlocked <= 1'b1;
    wr(clk_ctrl_pkg::OFS_PWR_CTRL, 32'h0A);
    chk({slow_rc_osc_on, fast_rc_osc_on, low_freq_crystal_on, hf_crystal_on}, 4'hA, "osc a");
    wr(clk_ctrl_pkg::OFS_PWR_CTRL, 32'h1F);
    chk({slow_rc_osc_on, fast_rc_osc_on, low_freq_crystal_on, hf_crystal_on}, 4'hF, "osc b");
  endtask : t_protect
  task t_select;
    int i;
    for (i = 1; i < 4; i++) begin
      wr(clk_ctrl_pkg::OFS_HS_GATE, 32'h1 << i);
      chk({ext_bus_clock_gate, flash_prog_clock_gate, dma_clock_gate}, 3'h1 << (i - 1), "gate");
    end
    tick_use_external <= 1'b1;
    for (i = 0; i < 6; i++) begin
      wr(clk_ctrl_pkg::OFS_CORE_SEL, (i == 5) ? 32'h3F : {26'h0, i[2:0], i[2:0]});
      chk(sys_source_onehot, 5'h1 << ((i == 5) ? 4 : i), "system source");
      chk(tick_source_onehot, 5'h1 << ((i == 5) ? 4 : i), "tick source");
    end
    wr(clk_ctrl_pkg::OFS_CORE_SEL, 32'h0);
    wr(clk_ctrl_pkg::OFS_PWR_CTRL, 32'h15);
    tick_use_external <= 1'b0;
    regs_unlocked <= 1'b0;
  endtask : t_select
  task t_idle;
    sleep_cmd <= 1'b1;
    tick(4);
    chk({cpu_clock_en, sys_clock_en, in_power_down}, 3'h2, "idle clocks");
    wake_cmd <= 1'b1;
    sleep_cmd <= 1'b0;
    tick(1);
    wake_cmd <= 1'b0;
    tick(6);
    chk(cpu_clock_en, 1'b1, "idle left");
    rdchk(clk_ctrl_pkg::OFS_PWR_CTRL, 32'h15, "wake ignored in run");
  endtask : t_idle
  task t_pd(input logic wait_cpu, input logic dly, input logic [2:0] src);
    logic [31:0] v;
    int n;
    v = 32'h25 | (32'(dly) << 4) | (32'(wait_cpu) << 8);
    regs_unlocked <= 1'b1;
    wr(clk_ctrl_pkg::OFS_PERIPH_GATE, 32'hFF);
    wr(clk_ctrl_pkg::OFS_PWR_CTRL, v);
    wr(clk_ctrl_pkg::OFS_PWR_CTRL, v | 32'h80);
    regs_unlocked <= 1'b0;
    if (wait_cpu) begin
      tick(10);
      chk(in_power_down, 1'b0, "waits for core sleep");
      sleep_cmd <= 1'b1;
    end
    wait_pd(1'b1, 6);
    tick(2);
    chk({hf_crystal_on, fast_rc_osc_on, pll_on, sys_clock_en}, 4'h0, "clocks down");
    chk(periph_clock_en, 32'h0F, "slow peripherals run");
    tick(20);
    chk(in_power_down, 1'b1, "stays down");
    wake_sel <= src;
    wake_cmd <= 1'b1;
    sleep_cmd <= 1'b0;
    n = 0;
    while (n < 60 && sys_clock_en !== 1'b1) begin
      @(posedge mclk);
      n++;
      if (n == 4) wake_cmd <= 1'b0;
    end
    wake_cmd <= 1'b0;
    if (dly) begin
      chk(n >= HF_DLY && n <= HF_DLY + 8, 1'b1, "wake delay length");
    end else begin
      chk(n <= 8, 1'b1, "no wake delay");
    end
    tick(2);
    chk(in_power_down, 1'b0, "woken");
    rdchk(clk_ctrl_pkg::OFS_PWR_CTRL, v | 32'h40, "request cleared, flag set");
    chk(wake_irq, 1'b1, "wake interrupt");
    wr(clk_ctrl_pkg::OFS_PWR_CTRL, 32'h40);
    rdchk(clk_ctrl_pkg::OFS_PWR_CTRL, v, "flag cleared only");
    chk(wake_irq, 1'b0, "wake interrupt cleared");
  endtask : t_pd
  task t_div;
    int r;
    int k;
    wr(clk_ctrl_pkg::OFS_PERIPH_GATE, 32'h40);
    for (k = 0; k < 6; k += 5) begin
      wr(clk_ctrl_pkg::OFS_FREQ_DIV, 32'h10 | k);
      tick(4);
      count_rises(64, r);
      chk(r, 64 >> (k + 1), "divider rate");
    end
    wr(clk_ctrl_pkg::OFS_FREQ_DIV, 32'h05);
    tick(70);
    count_rises(128, r);
    chk({r[7:0], divided_clock_out}, 9'h0, "stopped low");
    wr(clk_ctrl_pkg::OFS_FREQ_DIV, 32'h11);
    wr(clk_ctrl_pkg::OFS_PERIPH_GATE, 32'h0);
    count_rises(64, r);
    chk(r, 0, "gated divider");
    wr(clk_ctrl_pkg::OFS_PERIPH_GATE, 32'h40);
    count_rises(64, r);
    chk(r, 16, "ungated divider");
  endtask : t_div
  task t_cfg;
    cfg <= 3'h7;
    rst_b <= 1'b0;
    tick(4);
    rst_b <= 1'b1;
    tick(2);
    rdchk(clk_ctrl_pkg::OFS_PWR_CTRL, 32'h14, "rc reset");
    rdchk(clk_ctrl_pkg::OFS_CORE_SEL, 32'h3F, "rc select");
  endtask : t_cfg
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    tick(2);
    t_reset();
    t_protect();
    t_select();
    t_idle();
    t_pd(1'b0, 1'b1, 3'h0);
    t_pd(1'b1, 1'b0, 3'h7);
    t_div();
    t_cfg();
    final_report();
  end
endmodule : clock_power_down_controller_bench
